// [logic/bmc_pkg.sv]
// Constants, types and helper functions for the error monitor control block
package bmc_pkg;
  // ==========================================================
  // Register layout
  localparam int BMC_REG_W = 8;
  localparam logic [7:0] BMC_REG_RST = 8'h00;
  localparam int A_TIMER_HI = 7;
  localparam int A_TIMER_LO = 5;
  localparam int A_PHASE = 4;
  localparam int A_START = 3;
  localparam int A_BSEL_HI = 2;
  localparam int A_BSEL_LO = 0;
  localparam int B_ENABLE = 5;
  localparam int B_STANDBY = 4;
  localparam int B_STEP = 3;
  localparam int B_MODE_HI = 2;
  localparam int B_MODE_LO = 0;
  localparam logic SEL_A = 1'b0;
  localparam logic SEL_B = 1'b1;
  // ==========================================================
  // Codes and sizes
  localparam logic [2:0] BSEL_MAX = 3'h5;
  localparam logic [2:0] MODE_MAX = 3'h6;
  localparam logic [2:0] MODE_CHK_FIRST = 3'h5;
  localparam logic [2:0] SRC_NDC = 3'h0;
  localparam logic [2:0] SRC_DDC = 3'h1;
  localparam int TIMER_STEP_LOG2 = 3;
  localparam int WIN_BASE_LOG2_DEF = 18;
  localparam int BITCNT_W = 40;
  localparam int ERRCNT_W = 48;
  localparam int BYTE_W = 8;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE = 40'h00_0000_0001;
  localparam logic [ERRCNT_W-1:0] ERRCNT_ONE = 48'h0000_0000_0001;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    BMC_IDLE = 3'b001,
    BMC_RUN = 3'b010,
    BMC_DONE = 3'b100
  } bmc_state_t;
  typedef struct packed {
    logic en;
    logic sel;
    logic [BMC_REG_W-1:0] data;
  } bmc_wr_t;
  typedef struct packed {
    logic to_checker;
    logic [2:0] source;
  } bmc_route_t;
  localparam bmc_route_t ROUTE_RST = 4'h0;
  // ==========================================================
  // Helpers
  function automatic logic code_ok(input logic [2:0] code, input logic [2:0] max);
    code_ok = (code <= max);
  endfunction
  function automatic bmc_route_t route_of(input logic [2:0] code);
    bmc_route_t r;
    r.to_checker = (code >= MODE_CHK_FIRST);
    r.source = r.to_checker ? ((code == MODE_CHK_FIRST) ? SRC_NDC : SRC_DDC) : code;
    route_of = r;
  endfunction
endpackage

// [logic/bmc_top.sv]
// Bit error rate monitor control registers and measurement sequencer
// ==========================================================
`timescale 1ns/100ps
`default_nettype none
module bmc_top #(
  parameter int WIN_BASE_LOG2 = bmc_pkg::WIN_BASE_LOG2_DEF
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Register write port from the management interface
  input wire bmc_pkg::bmc_wr_t wr_in,
  // Recovered bit stream compare results
  input wire logic bit_valid_in,
  input wire logic bit_err_in,
  // Register readback
  output logic [bmc_pkg::BMC_REG_W-1:0] ctrl_a_out,
  output logic [bmc_pkg::BMC_REG_W-1:0] ctrl_b_out,
  output logic [bmc_pkg::BYTE_W-1:0] err_byte_out,
  // Monitor controls and status
  output logic phase_neg_out,
  output logic monitor_on_out,
  output logic standby_out,
  output logic xor_step_out,
  output bmc_pkg::bmc_route_t route_out,
  output logic meas_busy_out,
  output logic meas_done_out
);
  import bmc_pkg::*;

  // ==========================================================
  // State
  logic [BMC_REG_W-1:0] ctrl_a, next_ctrl_a;
  logic [BMC_REG_W-1:0] ctrl_b, next_ctrl_b;
  logic [2:0] bsel, next_bsel;
  bmc_route_t route, next_route;
  bmc_state_t state, next_state;
  logic [BITCNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [BITCNT_W-1:0] win_last, next_win_last;
  logic [ERRCNT_W-1:0] err_cnt, next_err_cnt;
  logic [BYTE_W-1:0] next_err_byte;
  logic next_step;
  logic start_pulse;
  logic next_busy, next_done;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    start_pulse = 1'b0;
    next_step = 1'b0;
    if (wr_in.en && wr_in.sel == SEL_A) begin
      next_ctrl_a = wr_in.data;
      // Falling edge of the written bit; a held 1 never restarts a window
      start_pulse = ctrl_a[A_START] && !wr_in.data[A_START];
    end
    if (wr_in.en && wr_in.sel == SEL_B) begin
      next_ctrl_b = wr_in.data;
      next_step = ctrl_b[B_STEP] && !wr_in.data[B_STEP];
    end
    next_bsel = bsel;
    if (code_ok(next_ctrl_a[A_BSEL_HI:A_BSEL_LO], BSEL_MAX)) begin
      next_bsel = next_ctrl_a[A_BSEL_HI:A_BSEL_LO];
    end
    next_route = route;
    if (code_ok(next_ctrl_b[B_MODE_HI:B_MODE_LO], MODE_MAX)) begin
      next_route = route_of(next_ctrl_b[B_MODE_HI:B_MODE_LO]);
    end
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_err_cnt = err_cnt;
    next_win_last = win_last;
    unique case (state)
      BMC_IDLE, BMC_DONE: begin
        if (start_pulse && ctrl_b[B_ENABLE]) begin
          next_state = BMC_RUN;
          next_bit_cnt = '0;
          next_err_cnt = '0;
          // Window is latched at start so a timer rewrite cannot cut a run short
          next_win_last = (BITCNT_ONE << (WIN_BASE_LOG2 +
            TIMER_STEP_LOG2 * int'(ctrl_a[A_TIMER_HI:A_TIMER_LO]))) - BITCNT_ONE;
        end
      end
      BMC_RUN: begin
        if (bit_valid_in && !ctrl_b[B_STANDBY]) begin
          next_bit_cnt = bit_cnt + BITCNT_ONE;
          // Wraps silently; 48 bits outlast even the longest window
          if (bit_err_in) begin
            next_err_cnt = err_cnt + ERRCNT_ONE;
          end
          if (bit_cnt == win_last) begin
            next_state = BMC_DONE;
          end
        end
      end
    endcase
    if (!ctrl_b[B_ENABLE]) begin
      next_state = BMC_IDLE;
    end
    next_err_byte = err_cnt[next_bsel*BYTE_W +: BYTE_W];
    // Status pins are registered from the next state so they come straight from flops
    next_busy = (next_state == BMC_RUN);
    next_done = (next_state == BMC_DONE);
  end

  // ==========================================================
  // Registers
  // No clock enable; each flop reloads its own value when nothing changes
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_a <= BMC_REG_RST;
      ctrl_b <= BMC_REG_RST;
      bsel <= '0;
      route <= ROUTE_RST;
      state <= BMC_IDLE;
      bit_cnt <= '0;
      win_last <= '0;
      err_cnt <= '0;
      err_byte_out <= '0;
      xor_step_out <= 1'b0;
      meas_busy_out <= 1'b0;
      meas_done_out <= 1'b0;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      bsel <= next_bsel;
      route <= next_route;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      win_last <= next_win_last;
      err_cnt <= next_err_cnt;
      err_byte_out <= next_err_byte;
      xor_step_out <= next_step;
      meas_busy_out <= next_busy;
      meas_done_out <= next_done;
    end
  end

  // Straight register taps
  assign ctrl_a_out = ctrl_a;
  assign ctrl_b_out = ctrl_b;
  assign phase_neg_out = ctrl_a[A_PHASE];
  assign monitor_on_out = ctrl_b[B_ENABLE];
  assign standby_out = ctrl_b[B_STANDBY];
  assign route_out = route;

  // ==========================================================
  // Assertions
  sequence s_write_a_fall;
    wr_in.en && wr_in.sel == SEL_A && ctrl_a[A_START] && !wr_in.data[A_START];
  endsequence
  sequence s_enabled_idle;
    ctrl_b[B_ENABLE] && !meas_busy_out;
  endsequence
  sequence s_write_b_fall;
    wr_in.en && wr_in.sel == SEL_B && ctrl_b[B_STEP] && !wr_in.data[B_STEP];
  endsequence

  AST_START_ON_FALL: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_enabled_idle ##0 s_write_a_fall ##1 ctrl_b[B_ENABLE] |-> meas_busy_out && bit_cnt == '0)
    else $error("measurement did not start on falling start bit");
  AST_NO_START_ON_LEVEL: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !meas_busy_out && !(wr_in.en && wr_in.sel == SEL_A) |=> !meas_busy_out)
    else $error("measurement started without a start pulse");
  AST_STEP_PULSE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    xor_step_out |-> $past(ctrl_b[B_STEP]) && !ctrl_b[B_STEP] ##1 !xor_step_out)
    else $error("step pulse not tied to a falling step bit");
  AST_DISABLE_IDLE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !ctrl_b[B_ENABLE] |=> !meas_busy_out && !meas_done_out)
    else $error("monitor active while disabled");
  AST_STANDBY_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    meas_busy_out && ctrl_b[B_STANDBY] |=> $stable(bit_cnt) && $stable(err_cnt))
    else $error("counters moved in standby");
  AST_BSEL_KEEP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_a[A_BSEL_HI:A_BSEL_LO] > BSEL_MAX |-> $stable(bsel))
    else $error("unused byte select changed readback");
  AST_ROUTE_MAP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_b[B_MODE_HI:B_MODE_LO] <= MODE_MAX |-> route == route_of(ctrl_b[B_MODE_HI:B_MODE_LO]))
    else $error("route does not match mode code");
  AST_RESET_ZERO: assert property (@(posedge clk_sys_in)
    srst_in |=> ctrl_a_out == BMC_REG_RST && ctrl_b_out == BMC_REG_RST)
    else $error("control registers not zero after reset");
  AST_WINDOW_END: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    meas_busy_out && ctrl_b[B_ENABLE] && bit_valid_in && !ctrl_b[B_STANDBY]
      && bit_cnt == win_last ##1 ctrl_b[B_ENABLE] |-> meas_done_out)
    else $error("window end not reached on last bit");
  AST_READBACK: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    1'b1 |=> err_byte_out == BYTE_W'($past(err_cnt) >> (bsel * BYTE_W)))
    else $error("readback byte mismatch");
  AST_STEP_ON_FALL: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_write_b_fall |=> xor_step_out)
    else $error("falling step bit gave no step pulse");
  AST_BSEL_TAKE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    code_ok(ctrl_a[A_BSEL_HI:A_BSEL_LO], BSEL_MAX) |-> bsel == ctrl_a[A_BSEL_HI:A_BSEL_LO])
    else $error("byte select not taken from control A");
  AST_ROUTE_KEEP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_b[B_MODE_HI:B_MODE_LO] > MODE_MAX |-> $stable(route))
    else $error("unused routing code changed route");
  AST_BIT_COUNT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    meas_busy_out && bit_valid_in && !ctrl_b[B_STANDBY]
      |=> bit_cnt == $past(bit_cnt) + BITCNT_ONE)
    else $error("counted bit not added to window count");
  AST_ERR_COUNT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    meas_busy_out && bit_valid_in && bit_err_in && !ctrl_b[B_STANDBY]
      |=> err_cnt == $past(err_cnt) + ERRCNT_ONE)
    else $error("errored bit not counted");
  AST_DONE_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    meas_done_out && ctrl_b[B_ENABLE] && !start_pulse |=> meas_done_out)
    else $error("finished window lost its done flag");
endmodule
`default_nettype wire

// [verif/tb_bmc_top.sv]
// Self-checking bench for the error monitor control block
`timescale 1ns/100ps
`default_nettype none
module tb_bmc_top;
  import bmc_pkg::*;
  // ==========================================================
  // Stimulus, model state and counters
  localparam int BASE = 2;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  bmc_wr_t wr_in = '0;
  logic bit_valid_in = 1'b0;
  logic bit_err_in = 1'b0;
  logic [7:0] ctrl_a_out, ctrl_b_out, err_byte_out, d;
  logic phase_neg_out, monitor_on_out, standby_out, xor_step_out, meas_busy_out, meas_done_out;
  bmc_route_t route_out, exp_route;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h1cf2;
  int n, k, win;
  longint errs;
  always #50 clk_sys_in = ~clk_sys_in;
  // Small window base keeps three timer codes inside the run budget
  bmc_top #(.WIN_BASE_LOG2(BASE)) DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .wr_in(wr_in), .bit_valid_in(bit_valid_in), .bit_err_in(bit_err_in),
    .ctrl_a_out(ctrl_a_out), .ctrl_b_out(ctrl_b_out), .err_byte_out(err_byte_out),
    .phase_neg_out(phase_neg_out), .monitor_on_out(monitor_on_out),
    .standby_out(standby_out), .xor_step_out(xor_step_out), .route_out(route_out),
    .meas_busy_out(meas_busy_out), .meas_done_out(meas_done_out));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] data);
    @(posedge clk_sys_in);
    wr_in <= '{en: 1'b1, sel: sel, data: data};
    @(posedge clk_sys_in);
    wr_in.en <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk("ctrl_a", 8'h00, ctrl_a_out);
    chk("ctrl_b", 8'h00, ctrl_b_out);
    chk("route", 8'h00, {4'h0, route_out});
    exp_route = '0;
    for (int m = 0; m < 8; m++) begin
      d = {2'b00, 2'($random(seed)), 1'b0, 3'(m)};
      if (m < 5)
        exp_route = {1'b0, 3'(m)};
      else if (m < 7)
        exp_route = {1'b1, 3'(m - 5)};
      wr(SEL_B, d);
      chk("ctrl_b", d, ctrl_b_out);
      chk("route", {4'h0, exp_route}, {4'h0, route_out});
      chk("monitor_on", {7'h0, d[5]}, {7'h0, monitor_on_out});
      chk("standby", {7'h0, d[4]}, {7'h0, standby_out});
    end
    wr(SEL_B, 8'h28);
    chk("xor_step", 8'h00, {7'h0, xor_step_out});
    wr(SEL_B, 8'h20);
    chk("xor_step", 8'h01, {7'h0, xor_step_out});
    @(posedge clk_sys_in);
    #1;
    chk("xor_step", 8'h00, {7'h0, xor_step_out});
    for (int t = 0; t < 3; t++) begin
      win = 4 << (3 * t);
      n = 0;
      errs = 0;
      wr(SEL_B, 8'h30);
      wr(SEL_A, {3'(t), 5'h08});
      chk("busy", 8'h00, {7'h0, meas_busy_out});
      wr(SEL_A, {3'(t), 5'h00});
      // Standby must swallow more valid bits than the shortest window
      repeat (8) @(posedge clk_sys_in) bit_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      bit_valid_in <= 1'b0;
      #1;
      chk("done", 8'h00, {7'h0, meas_done_out});
      wr(SEL_B, 8'h20);
      k = 0;
      while (n < win) begin
        @(posedge clk_sys_in);
        d = 8'($random(seed));
        bit_valid_in <= d[0];
        bit_err_in <= d[1];
        n += d[0];
        errs += d[0] & d[1];
        k++;
        if (k > 4000) begin
          bad_count++;
          summarize();
        end
        #1;
        chk("busy", 8'h01, {7'h0, meas_busy_out});
        chk("done", 8'h00, {7'h0, meas_done_out});
      end
      @(posedge clk_sys_in);
      bit_valid_in <= 1'b0;
      bit_err_in <= 1'b0;
      #1;
      chk("done", 8'h01, {7'h0, meas_done_out});
      chk("busy", 8'h00, {7'h0, meas_busy_out});
      for (int b = 0; b < 8; b++) begin
        d = {3'(t), 1'(b), 1'b0, 3'(b)};
        wr(SEL_A, d);
        chk("ctrl_a", d, ctrl_a_out);
        @(posedge clk_sys_in);
        #1;
        chk("phase_neg", {7'h0, 1'(b)}, {7'h0, phase_neg_out});
        chk("err_byte", 8'(errs >> (8 * (b < 6 ? b : 5))), err_byte_out);
      end
      chk("done", 8'h01, {7'h0, meas_done_out});
    end
    wr(SEL_B, 8'h00);
    @(posedge clk_sys_in);
    #1;
    chk("done", 8'h00, {7'h0, meas_done_out});
    wr(SEL_A, 8'h08);
    wr(SEL_A, 8'h00);
    @(posedge clk_sys_in);
    #1;
    chk("busy", 8'h00, {7'h0, meas_busy_out});
    summarize();
  end
endmodule
`default_nettype wire
